/* File: src/tsc_sync_cal.v */
// Behaviour
// - after an eoi byte, serial poll answers only once all queued commands finish
// - eoi byte switches to serial mode; next byte handshake held until queue drains
// - opc command sets the opc event bit after all earlier commands completed
// - opc query answers character 1 after itself and earlier commands completed
// - wait command does nothing since commands never overlap
// - interface clear abandons any byte handshake in progress
// - device clear resets command parsers; next byte starts a message header
// - device clear clears status registers but leaves the answer queue alone
// - reset command resets hardware to defaults; device uncalibrated until data reloaded
// - adc query returns conversion result up to 4095, or -1 on failure
// - mainframe selector 1,2,3 or all; adc calibration precedes mainframe level calibration and mainframe level writes
// - level or timing calibration may corrupt expected data; reload before test
// - ac timing calibration only measures, never alters stored calibration values
// - standard ac calibration per channel; user calibration uses pin and timing setup
// - calibration init with u option starts user calibration
// - calibration mode accepts only calibration commands, not init, using given period
`timescale 1ns/1ps
`include "tsc_defs.vh"
module tsc_sync_cal #(
	parameter DEPTH     = 8,
	parameter AW        = 3,
	parameter MF_PRESENT = 3'h7
) (
	input  wire                   clk,
	input  wire                   rst,
	input  wire                   cmd_valid,
	output wire                   cmd_ready,
	input  wire [`TSC_CODE_W-1:0] cmd_code,
	input  wire [1:0]             cmd_sel,
	input  wire [`TSC_ARG_W-1:0]  cmd_arg,
	input  wire                   cmd_user,
	input  wire                   cmd_eoi,
	input  wire                   ifc,
	input  wire                   dcl,
	input  wire                   spoll_req,
	output wire                   spoll_ack,
	output reg                    exec_valid_r,
	output reg  [`TSC_CODE_W-1:0] exec_code_r,
	output reg  [1:0]             exec_sel_r,
	output reg  [`TSC_ARG_W-1:0]  exec_arg_r,
	output reg                    exec_user_r,
	output reg                    exec_may_write_r,
	input  wire                   exec_done,
	input  wire                   exec_fail,
	input  wire [`TSC_ARG_W-1:0]  exec_result,
	output reg                    resp_valid_r,
	output reg  [`TSC_ARG_W-1:0]  resp_data_r,
	output reg                    parser_clear_r,
	output reg                    hw_reset_r,
	output reg                    exec_error_r,
	output reg  [`TSC_ESR_W-1:0]  esr_r,
	output wire                   calibrated,
	output reg                    cal_mode_r,
	output reg                    cal_user_r,
	output reg  [`TSC_ARG_W-1:0]  cal_period_r,
	output reg                    expect_stale_r
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LOAD = 2'h1;
	localparam ST_RUN  = 2'h2;
	localparam ST_WAIT = 2'h3;

	reg  [1:0]               state_r;
	reg  [AW-1:0]            wr_ptr_r;
	reg  [AW-1:0]            rd_ptr_r;
	reg  [AW:0]              count_r;
	reg                      hold_r;
	reg  [2:0]               adc_done_r;
	reg  [`TSC_CALDATA_W-1:0] caldata_r;
	reg  [`TSC_WORD_W-1:0]   word_r;
	wire [`TSC_WORD_W-1:0]   mem_rd_data;
	wire                     push;
	wire                     pop;
	wire                     busy;
	wire [`TSC_CODE_W-1:0]   w_code;
	wire [1:0]               w_sel;
	reg                      opc_set;
	reg                      exe_set;

	function is_cal;
		input [`TSC_CODE_W-1:0] c;
		begin
			is_cal = (c >= `TSC_ADC_CONVERT_Q) && (c <= `TSC_CAL_PERIOD_SET);
		end
	endfunction

	function is_mf;
		input [`TSC_CODE_W-1:0] c;
		begin
			is_mf = (c == `TSC_ADC_CONVERT_Q) || (c == `TSC_MF_LEVEL_CAL_Q)
				|| (c == `TSC_MF_LEVEL_WR);
		end
	endfunction

	function [2:0] sel_mask;
		input [1:0] s;
		begin
			if (s == `TSC_SEL_ALL) begin
				sel_mask = MF_PRESENT;
			end else begin
				sel_mask = 3'h1 << (s - 2'h1);
			end
		end
	endfunction

	assign busy      = (count_r != {(AW+1){1'b0}}) || (state_r != ST_IDLE)
		|| opc_set || exe_set;
	assign cmd_ready = !hold_r && !ifc && (count_r < DEPTH);
	assign push      = cmd_valid && cmd_ready;
	assign pop       = (state_r == ST_LOAD);
	assign spoll_ack = spoll_req && !busy;
	assign calibrated = (caldata_r == `TSC_CALDATA_ALL);
	assign w_code    = word_r[`TSC_F_CODE_LSB +: `TSC_CODE_W];
	assign w_sel     = word_r[`TSC_F_SEL_LSB +: 2];

	tsc_cmd_mem #(
		.WIDTH (`TSC_WORD_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk     (clk),
		.wr_en   (push),
		.wr_addr (wr_ptr_r),
		.wr_data ({cmd_code, cmd_sel, cmd_user, cmd_arg}),
		.rd_addr (rd_ptr_r),
		.rd_data (mem_rd_data)
	);

	// queue pointers and eoi holdoff
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
			hold_r   <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH-1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH-1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			if (ifc) begin
				hold_r <= 1'b0;
			end else if (push && cmd_eoi) begin
				hold_r <= 1'b1;
			end else if (!busy) begin
				hold_r <= 1'b0;
			end
		end
	end

	// in-order single-command executor
	always @(posedge clk) begin
		if (rst) begin
			state_r          <= ST_IDLE;
			word_r           <= {`TSC_WORD_W{1'b0}};
			exec_valid_r     <= 1'b0;
			exec_code_r      <= `TSC_OPC_CMD;
			exec_sel_r       <= 2'h0;
			exec_arg_r       <= {`TSC_ARG_W{1'b0}};
			exec_user_r      <= 1'b0;
			exec_may_write_r <= 1'b0;
			resp_valid_r     <= 1'b0;
			resp_data_r      <= {`TSC_ARG_W{1'b0}};
			hw_reset_r       <= 1'b0;
			exec_error_r     <= 1'b0;
			opc_set          <= 1'b0;
			exe_set          <= 1'b0;
			cal_mode_r       <= 1'b0;
			cal_user_r       <= 1'b0;
			cal_period_r     <= {`TSC_ARG_W{1'b0}};
			adc_done_r       <= 3'h0;
			caldata_r        <= {`TSC_CALDATA_W{1'b0}};
			expect_stale_r   <= 1'b0;
		end else begin
			resp_valid_r <= 1'b0;
			hw_reset_r   <= 1'b0;
			exec_error_r <= 1'b0;
			opc_set      <= 1'b0;
			exe_set      <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (count_r != {(AW+1){1'b0}}) begin
					state_r <= ST_LOAD;
				end
			end
			ST_LOAD: begin
				word_r  <= mem_rd_data;
				state_r <= ST_RUN;
			end
			ST_RUN: begin
				state_r <= ST_IDLE;
				if (cal_mode_r && (!is_cal(w_code) || w_code == `TSC_CAL_INIT_Q)
					&& w_code != `TSC_CAL_TERMINATE) begin
					exec_error_r <= 1'b1;
					exe_set      <= 1'b1;
				end else if (is_mf(w_code) && ((sel_mask(w_sel) & ~MF_PRESENT) != 3'h0)) begin
					exec_error_r <= 1'b1;
					exe_set      <= 1'b1;
				end else if (is_mf(w_code) && w_code != `TSC_ADC_CONVERT_Q
					&& ((sel_mask(w_sel) & ~adc_done_r) != 3'h0)) begin
					exec_error_r <= 1'b1;
					exe_set      <= 1'b1;
				end else begin
					case (w_code)
					`TSC_OPC_CMD: begin
						opc_set <= 1'b1;
					end
					`TSC_OPC_QUERY: begin
						resp_valid_r <= 1'b1;
						resp_data_r  <= `TSC_ANS_ONE;
					end
					`TSC_WAIT_CMD: begin
						state_r <= ST_IDLE;
					end
					`TSC_RESET_CMD: begin
						hw_reset_r     <= 1'b1;
						caldata_r      <= {`TSC_CALDATA_W{1'b0}};
						adc_done_r     <= 3'h0;
						cal_mode_r     <= 1'b0;
						cal_user_r     <= 1'b0;
						expect_stale_r <= 1'b0;
					end
					`TSC_CAL_TERMINATE: begin
						cal_mode_r <= 1'b0;
						cal_user_r <= 1'b0;
					end
					default: begin
						state_r          <= ST_WAIT;
						exec_valid_r     <= 1'b1;
						exec_code_r      <= w_code;
						exec_sel_r       <= w_sel;
						exec_arg_r       <= (cal_mode_r && is_cal(w_code)) ? cal_period_r
							: word_r[`TSC_F_ARG_LSB +: `TSC_ARG_W];
						exec_user_r      <= (w_code == `TSC_DRV_USER_CAL_Q)
							|| (w_code == `TSC_RCV_USER_CAL_Q);
						exec_may_write_r <= !((w_code >= `TSC_CAL_INIT_Q)
							&& (w_code <= `TSC_PROBE_SEARCH_Q));
					end
					endcase
				end
			end
			ST_WAIT: begin
				if (exec_done) begin
					exec_valid_r <= 1'b0;
					state_r      <= ST_IDLE;
					if (exec_code_r == `TSC_ADC_CONVERT_Q) begin
						resp_valid_r <= 1'b1;
						resp_data_r  <= exec_fail ? `TSC_ANS_FAIL
							: {{(`TSC_ARG_W-`TSC_ADC_W){1'b0}}, exec_result[`TSC_ADC_W-1:0]};
						if (!exec_fail) begin
							adc_done_r <= adc_done_r | sel_mask(exec_sel_r);
						end
					end else if (exec_fail) begin
						exec_error_r <= 1'b1;
						exe_set      <= 1'b1;
					end else begin
						if (exec_code_r <= `TSC_PROBE_SEARCH_Q) begin
							resp_valid_r <= 1'b1;
							resp_data_r  <= exec_result;
						end
						if (exec_code_r >= `TSC_MF_LEVEL_CAL_Q && exec_code_r <= `TSC_RCV_USER_CAL_Q) begin
							expect_stale_r <= 1'b1;
						end
						case (exec_code_r)
						`TSC_CAL_INIT_Q: begin
							cal_mode_r   <= 1'b1;
							cal_user_r   <= exec_user_r | word_r[`TSC_F_USER_BIT];
							cal_period_r <= exec_arg_r;
						end
						`TSC_MF_LEVEL_WR: caldata_r[0] <= 1'b1;
						`TSC_DRV_LEVEL_WR: caldata_r[1] <= 1'b1;
						`TSC_RCV_LEVEL_WR: caldata_r[2] <= 1'b1;
						`TSC_DRV_TIMING_WR: caldata_r[3] <= 1'b1;
						`TSC_RCV_TIMING_WR: caldata_r[4] <= 1'b1;
						`TSC_EXPECT_RELOAD: expect_stale_r <= 1'b0;
						default: begin
							cal_mode_r <= cal_mode_r;
						end
						endcase
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// event status and device clear
	always @(posedge clk) begin
		if (rst) begin
			esr_r          <= `TSC_ESR_RST;
			parser_clear_r <= 1'b0;
		end else begin
			parser_clear_r <= dcl;
			if (dcl) begin
				esr_r <= `TSC_ESR_RST;
			end
			if (opc_set) begin
				esr_r[`TSC_ESR_OPC_BIT] <= 1'b1;
			end
			if (exe_set) begin
				esr_r[`TSC_ESR_EXE_BIT] <= 1'b1;
			end
		end
	end
endmodule // tsc_sync_cal

/* File: src/tsc_defs.vh */
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH

// command codes delivered by the front-end decoder
`define TSC_CODE_W            5
`define TSC_OPC_CMD           5'h00
`define TSC_OPC_QUERY         5'h01
`define TSC_WAIT_CMD          5'h02
`define TSC_RESET_CMD         5'h03
`define TSC_ADC_CONVERT_Q     5'h04
`define TSC_MF_LEVEL_CAL_Q    5'h05
`define TSC_DRV_LEVEL_CAL_Q   5'h06
`define TSC_RCV_LEVEL_CAL_Q   5'h07
`define TSC_CAL_INIT_Q        5'h08
`define TSC_DRV_TIMING_CAL_Q  5'h09
`define TSC_RCV_TIMING_CAL_Q  5'h0A
`define TSC_DRV_USER_CAL_Q    5'h0B
`define TSC_RCV_USER_CAL_Q    5'h0C
`define TSC_CAL_TERMINATE     5'h0D
`define TSC_PROBE_SEARCH_Q    5'h0E
`define TSC_MF_LEVEL_WR       5'h0F
`define TSC_DRV_LEVEL_WR      5'h10
`define TSC_RCV_LEVEL_WR      5'h11
`define TSC_DRV_TIMING_WR     5'h12
`define TSC_RCV_TIMING_WR     5'h13
`define TSC_DRV_USER_WR       5'h14
`define TSC_RCV_USER_WR       5'h15
`define TSC_CAL_PERIOD_SET    5'h16
`define TSC_EXPECT_RELOAD     5'h17
`define TSC_GENERIC_CMD       5'h18

// mainframe selector encoding
`define TSC_SEL_ALL           2'h0

// queued command word layout
`define TSC_ARG_W             16
`define TSC_WORD_W            24
`define TSC_F_CODE_LSB        19
`define TSC_F_SEL_LSB         17
`define TSC_F_USER_BIT        16
`define TSC_F_ARG_LSB         0

// event status bits
`define TSC_ESR_W             8
`define TSC_ESR_OPC_BIT       0
`define TSC_ESR_EXE_BIT       4
`define TSC_ESR_RST           8'h00

// answers
`define TSC_ANS_ONE           16'h0031
`define TSC_ANS_FAIL          16'hFFFF
`define TSC_ADC_W             12

// calibration data kinds that must all be reloaded after reset
`define TSC_CALDATA_W         5
`define TSC_CALDATA_ALL       5'h1F

`endif

/* File: src/tsc_cmd_mem.v */
`timescale 1ns/1ps
module tsc_cmd_mem #(
	parameter WIDTH = 24,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_addr,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [AW-1:0]    rd_addr,
	output reg  [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // tsc_cmd_mem

/* File: verif/tsc_exec_model.sv */
`timescale 1ns/1ps
module tsc_exec_model (
	input  wire        clk,
	input  wire        rst,
	input  wire        exec_valid_r,
	input  wire [15:0] exec_arg_r,
	input  wire [7:0]  lat,
	input  wire        fail,
	output reg         exec_done,
	output reg         exec_fail,
	output reg  [15:0] exec_result
);
	reg [7:0] cnt_r;
	// answers lat+1 cycles after a request; idle data lines keep toggling
	always @(posedge clk) begin
		exec_done <= 1'b0;
		exec_fail <= rst ? 1'b0 : ~exec_fail;
		exec_result <= rst ? 16'h0000 : ~exec_result;
		if (rst || !exec_valid_r || exec_done)
			cnt_r <= 8'h00;
		else if (cnt_r == lat) begin
			exec_done <= 1'b1;
			exec_fail <= fail;
			exec_result <= 16'hA000 | exec_arg_r;
		end else
			cnt_r <= cnt_r + 8'h01;
	end
endmodule // tsc_exec_model

/* File: verif/tsc_monitor.sv */
`timescale 1ns/1ps
`include "tsc_defs.vh"
module tsc_monitor (
	input wire        clk,
	input wire        rst,
	input wire        cmd_valid,
	input wire        cmd_ready,
	input wire        cmd_eoi,
	input wire        ifc,
	input wire        spoll_req,
	input wire        spoll_ack,
	input wire        exec_valid_r,
	input wire [4:0]  exec_code_r,
	input wire [15:0] exec_arg_r,
	input wire        exec_may_write_r,
	input wire        exec_user_r,
	input wire        exec_done,
	input wire        exec_fail,
	input wire        resp_valid_r,
	input wire [15:0] resp_data_r,
	input wire        hw_reset_r,
	input wire        exec_error_r,
	input wire [7:0]  esr_r,
	input wire        calibrated,
	input wire        cal_mode_r,
	input wire        cal_user_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_spoll_idle: assert property (spoll_ack |-> spoll_req && !exec_valid_r)
		else $error("poll answered while busy");
	a_eoi_hold: assert property (cmd_valid && cmd_ready && cmd_eoi |=> !cmd_ready)
		else $error("no holdoff after eoi");
	a_ifc_block: assert property (ifc |-> !cmd_ready)
		else $error("ready during ifc");
	a_exec_hold: assert property (exec_valid_r && !exec_done |=> exec_valid_r
		&& $stable(exec_code_r) && $stable(exec_arg_r))
		else $error("request changed early");
	a_exec_drop: assert property (exec_valid_r && exec_done |=> !exec_valid_r)
		else $error("request held after done");
	a_ac_nowrite: assert property (exec_valid_r && exec_code_r >= `TSC_CAL_INIT_Q
		&& exec_code_r <= `TSC_PROBE_SEARCH_Q |-> !exec_may_write_r)
		else $error("timing cal may write");
	a_adc_fail: assert property (exec_valid_r && exec_done && exec_fail
		&& exec_code_r == `TSC_ADC_CONVERT_Q |=> resp_valid_r
		&& resp_data_r == `TSC_ANS_FAIL)
		else $error("adc failure not reported");
	a_user_cal: assert property (exec_valid_r |-> exec_user_r ==
		(exec_code_r == `TSC_DRV_USER_CAL_Q || exec_code_r == `TSC_RCV_USER_CAL_Q))
		else $error("user flag wrong");
	a_err_event: assert property (exec_error_r |=> esr_r[`TSC_ESR_EXE_BIT])
		else $error("error event lost");
	a_poll_settled: assert property (spoll_ack |-> !exec_error_r)
		else $error("poll answered before status settled");
	a_reset_cal: assert property (hw_reset_r |=> !calibrated && !cal_mode_r)
		else $error("calibrated after reset");
	cover property (spoll_req && spoll_ack);
	cover property (hw_reset_r);
	cover property (cal_mode_r && cal_user_r);
endmodule // tsc_monitor

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`include "tsc_defs.vh"
module testbench;
	reg         clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_user = 1'b0, cmd_eoi = 1'b0;
	reg         ifc = 1'b0, dcl = 1'b0, spoll_req = 1'b1, fail = 1'b0;
	reg  [4:0]  cmd_code = 5'h00;
	reg  [1:0]  cmd_sel = 2'h0;
	reg  [15:0] cmd_arg = 16'h0000;
	reg  [7:0]  lat = 8'h02;
	wire        cmd_ready, spoll_ack, exec_valid_r, exec_user_r, exec_may_write_r, exec_done;
	wire        exec_fail, resp_valid_r, parser_clear_r, hw_reset_r, exec_error_r, calibrated;
	wire        cal_mode_r, cal_user_r, expect_stale_r;
	wire [4:0]  exec_code_r;
	wire [1:0]  exec_sel_r;
	wire [7:0]  esr_r;
	wire [15:0] exec_arg_r, exec_result, resp_data_r, cal_period_r;
	integer     fail_count = 0, n_compared = 0, i, k;

	always #10 clk = ~clk;
	tsc_sync_cal dut (.*);
	tsc_exec_model model (.*);

	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tmo;
		chk("wait", 16'h0000, 16'h0001);
		end_of_test;
	endtask
	// offer one command, held until taken
	task send(input [4:0] c, input [1:0] s, input [15:0] a);
		@(negedge clk);
		{cmd_code, cmd_sel, cmd_arg, cmd_valid} = {c, s, a, 1'b1};
		for (i = 0; i < 300 && cmd_ready !== 1'b1; i = i + 1) @(negedge clk);
		if (cmd_ready !== 1'b1) tmo;
		@(negedge clk);
		{cmd_valid, cmd_eoi, cmd_user} = 3'h0;
	endtask
	task get_resp(input [15:0] exp);
		for (i = 0; i < 400 && resp_valid_r !== 1'b1; i = i + 1) @(negedge clk);
		if (resp_valid_r !== 1'b1) tmo;
		chk("resp", resp_data_r, exp);
		@(negedge clk);
	endtask
	task idle;
		for (i = 0; i < 400 && spoll_ack !== 1'b1; i = i + 1) @(negedge clk);
		if (spoll_ack !== 1'b1) tmo;
	endtask
	task t_adc;
		send(`TSC_MF_LEVEL_CAL_Q, 2'h1, 16'h0000);
		idle;
		chk("esr_exe", esr_r[4], 1'b1);
		{lat, fail} = {8'h14, 1'b1};
		send(`TSC_ADC_CONVERT_Q, `TSC_SEL_ALL, 16'h0FFF);
		get_resp(`TSC_ANS_FAIL);
		fail = 1'b0;
		for (k = 1; k < 4; k = k + 1)
			send(`TSC_ADC_CONVERT_Q, k[1:0], 16'h0FFF);
		send(`TSC_OPC_QUERY, 2'h0, 16'h0000);
		for (k = 1; k < 4; k = k + 1)
			get_resp(16'h0FFF);
		get_resp(`TSC_ANS_ONE);
	endtask
	task t_dcl;
		dcl = 1'b1;
		@(negedge clk);
		dcl = 1'b0;
		chk("esr", esr_r, 8'h00);
		chk("parse_clr", parser_clear_r, 1'b1);
		chk("resp_kept", resp_data_r, `TSC_ANS_ONE);
	endtask
	task t_opc;
		send(`TSC_MF_LEVEL_CAL_Q, `TSC_SEL_ALL, 16'h0000);
		send(`TSC_OPC_CMD, 2'h0, 16'h0000);
		get_resp(16'hA000);
		chk("opc_early", esr_r[0], 1'b0);
		idle;
		chk("opc", esr_r[0], 1'b1);
		spoll_req = 1'b0;
		@(negedge clk);
		chk("poll_req", spoll_ack, 1'b0);
		spoll_req = 1'b1;
	endtask
	task t_hold;
		lat = 8'h1E;
		send(`TSC_WAIT_CMD, 2'h0, 16'h0000);
		cmd_eoi = 1'b1;
		send(`TSC_DRV_LEVEL_CAL_Q, 2'h0, 16'h0007);
		chk("hold_rdy", cmd_ready, 1'b0);
		chk("hold_poll", spoll_ack, 1'b0);
		ifc = 1'b1;
		@(negedge clk);
		ifc = 1'b0;
		@(negedge clk);
		chk("ifc_rdy", cmd_ready, 1'b1);
		get_resp(16'hA007);
	endtask
	task t_cal;
		idle;
		{lat, cmd_user} = {8'h02, 1'b0};
		send(`TSC_MF_LEVEL_WR, `TSC_SEL_ALL, 16'h0C35);
		cmd_user = 1'b1;
		send(`TSC_CAL_INIT_Q, 2'h0, 16'h0123);
		get_resp(16'hA123);
		chk("cal_user", cal_user_r, 1'b1);
		chk("cal_per", cal_period_r, 16'h0123);
		for (k = `TSC_DRV_TIMING_CAL_Q; k <= `TSC_PROBE_SEARCH_Q; k = k + 1) begin
			if (k != `TSC_CAL_TERMINATE) begin
				send(k[4:0], 2'h1, 16'h0055);
				get_resp(16'hA123);
			end
		end
		send(`TSC_CAL_INIT_Q, 2'h0, 16'h0123);
		send(`TSC_OPC_QUERY, 2'h0, 16'h0000);
		idle;
		chk("cal_refuse", esr_r[4], 1'b1);
		chk("cal_noans", resp_data_r, 16'hA123);
		chk("stale", expect_stale_r, 1'b1);
		send(`TSC_CAL_TERMINATE, 2'h0, 16'h0000);
		send(`TSC_EXPECT_RELOAD, 2'h0, 16'h0000);
		idle;
		chk("cal_exit", cal_mode_r, 1'b0);
		chk("stale_clr", expect_stale_r, 1'b0);
	endtask
	task t_rst;
		for (k = `TSC_MF_LEVEL_WR; k <= `TSC_RCV_TIMING_WR; k = k + 1)
			send(k[4:0], `TSC_SEL_ALL, 16'h0100);
		idle;
		chk("cal_ok", calibrated, 1'b1);
		send(`TSC_RESET_CMD, 2'h0, 16'h0000);
		idle;
		chk("uncal", calibrated, 1'b0);
	endtask

	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_adc;
		t_dcl;
		t_opc;
		t_hold;
		t_cal;
		t_rst;
		end_of_test;
	end
endmodule // testbench

bind tsc_sync_cal tsc_monitor mon (
	.clk              (clk),
	.rst              (rst),
	.cmd_valid        (cmd_valid),
	.cmd_ready        (cmd_ready),
	.cmd_eoi          (cmd_eoi),
	.ifc              (ifc),
	.spoll_req        (spoll_req),
	.spoll_ack        (spoll_ack),
	.exec_valid_r     (exec_valid_r),
	.exec_code_r      (exec_code_r),
	.exec_arg_r       (exec_arg_r),
	.exec_may_write_r (exec_may_write_r),
	.exec_user_r      (exec_user_r),
	.exec_done        (exec_done),
	.exec_fail        (exec_fail),
	.resp_valid_r     (resp_valid_r),
	.resp_data_r      (resp_data_r),
	.hw_reset_r       (hw_reset_r),
	.exec_error_r     (exec_error_r),
	.esr_r            (esr_r),
	.calibrated       (calibrated),
	.cal_mode_r       (cal_mode_r),
	.cal_user_r       (cal_user_r)
);
